// >>> src/perpp_pkg.sv
/*
 package of constants and state types for the parallel eeprom host controller.
 assumes a single 250 MHz core clock; all pin timing is counted in its cycles.
*/
package perpp_pkg;

	// ----------------------------------------
	// clock and widths
	// ----------------------------------------
	localparam int CLK_PS     = 4000;
	localparam int ADDR_W     = 15;
	localparam int DATA_W     = 8;
	localparam int PAGE_LSB   = 7;
	localparam int CMPL_BIT   = 7;
	localparam int TOGGLE_BIT = 6;
	localparam logic [7:0] PAGE_BYTES = 8'h80;

	// ----------------------------------------
	// pin timing, in ns and in cycles
	// ----------------------------------------
	localparam int ACCESS_NS   = 70;
	localparam int SETUP_NS    = 20;
	localparam int WE_PULSE_NS = 100;
	localparam int HOLD_NS     = 20;
	localparam int RECOV_NS    = 20;
	localparam int SYNC_CYC    = 2;
	localparam int ACCESS_CYC  = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int READ_CYC    = ACCESS_CYC + SYNC_CYC;
	localparam int SETUP_CYC   = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int PULSE_CYC   = (WE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int HOLD_CYC    = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int RECOV_CYC   = (RECOV_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam logic [7:0] SETUP_LD = 8'(SETUP_CYC - 1);
	localparam logic [7:0] PULSE_LD = 8'(PULSE_CYC - 1);
	localparam logic [7:0] HOLD_LD  = 8'(HOLD_CYC - 1);
	localparam logic [7:0] READ_LD  = 8'(READ_CYC - 1);
	localparam logic [7:0] RECOV_LD = 8'(RECOV_CYC - 1);

	// ----------------------------------------
	// page load window
	// ----------------------------------------
	localparam int PAGE_WIN_US   = 100;
	localparam int PAGE_WIN_CYC  = PAGE_WIN_US * 1000000 / CLK_PS;
	localparam int WIN_MARGIN    = SETUP_CYC + 2;
	localparam int CLOSE_GUARD   = 250;
	localparam logic [15:0] WIN_RST = 16'h0000;

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum logic [2:0] {
		CY_IDLE   = 3'b000,
		CY_SETUP  = 3'b001,
		CY_STROBE = 3'b011,
		CY_HOLD   = 3'b010,
		CY_READ   = 3'b100,
		CY_RECOV  = 3'b101
	} perpp_cyc_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WR   = 3'b001,
		ST_OPEN = 3'b011,
		ST_WAIT = 3'b010,
		ST_POLL = 3'b110,
		ST_RD   = 3'b100
	} perpp_state_t;

endpackage : perpp_pkg

// >>> src/perpp_cycle.sv
/*
 one bus cycle on the memory pins: a byte write strobed by the write strobe, or a read.
 assumes start only while idle; data_lines_in comes from the pins, unsynchronised.
*/
`timescale 1ns/10ps
module perpp_cycle (
	input  wire logic                        core_clk,
	input  wire logic                        srst,
	input  wire logic                        start,
	input  wire logic                        is_write,
	input  wire logic [perpp_pkg::ADDR_W-1:0] addr,
	input  wire logic [perpp_pkg::DATA_W-1:0] wdata,
	input  wire logic [perpp_pkg::DATA_W-1:0] data_lines_in,
	output logic                             done,
	output logic                             we_fall,
	output logic      [perpp_pkg::DATA_W-1:0] rdata,
	output logic                             ce_n,
	output logic                             oe_n,
	output logic                             we_n,
	output logic      [perpp_pkg::ADDR_W-1:0] byte_address,
	output logic      [perpp_pkg::DATA_W-1:0] data_lines_out,
	output logic                             data_lines_oe
);

	perpp_pkg::perpp_cyc_t             st_ff, nxt_st;
	logic [7:0]                        cnt_ff, nxt_cnt;
	logic                              ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n;
	logic                              done_ff, nxt_done, fall_ff, nxt_fall, dq_oe_ff, nxt_dq_oe;
	logic [perpp_pkg::ADDR_W-1:0]      addr_ff, nxt_addr;
	logic [perpp_pkg::DATA_W-1:0]      dq_ff, nxt_dq, rdata_ff, nxt_rdata;
	logic [perpp_pkg::DATA_W-1:0]      dq_meta_ff, dq_sync_ff;
	wire                               cnt_zero = (cnt_ff == 8'h00);

	// ----------------------------------------
	// cycle sequencer
	// ----------------------------------------
	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_zero ? 8'h00 : cnt_ff - 8'h01;
		nxt_ce_n  = ce_n_ff;
		nxt_oe_n  = oe_n_ff;
		nxt_we_n  = we_n_ff;
		nxt_addr  = addr_ff;
		nxt_dq    = dq_ff;
		nxt_dq_oe = dq_oe_ff;
		nxt_rdata = rdata_ff;
		nxt_done  = 1'b0;
		nxt_fall  = 1'b0;
		case (st_ff)
			perpp_pkg::CY_IDLE: begin
				if (start) begin
					nxt_addr = addr;
					nxt_ce_n = 1'b0;
					if (is_write) begin
						nxt_dq    = wdata;
						nxt_dq_oe = 1'b1;
						nxt_st    = perpp_pkg::CY_SETUP;
						nxt_cnt   = perpp_pkg::SETUP_LD;
					end else begin
						nxt_oe_n = 1'b0;
						nxt_st   = perpp_pkg::CY_READ;
						nxt_cnt  = perpp_pkg::READ_LD;
					end
				end
			end
			perpp_pkg::CY_SETUP: begin
				if (cnt_zero) begin
					nxt_we_n = 1'b0;
					nxt_fall = 1'b1;
					nxt_st   = perpp_pkg::CY_STROBE;
					nxt_cnt  = perpp_pkg::PULSE_LD;
				end
			end
			perpp_pkg::CY_STROBE: begin
				if (cnt_zero) begin
					nxt_we_n = 1'b1;
					nxt_st   = perpp_pkg::CY_HOLD;
					nxt_cnt  = perpp_pkg::HOLD_LD;
				end
			end
			perpp_pkg::CY_HOLD: begin
				if (cnt_zero) begin
					nxt_ce_n  = 1'b1;
					nxt_dq_oe = 1'b0;
					nxt_done  = 1'b1;
					nxt_st    = perpp_pkg::CY_IDLE;
				end
			end
			perpp_pkg::CY_READ: begin
				if (cnt_zero) begin
					nxt_rdata = dq_sync_ff;
					nxt_ce_n  = 1'b1;
					nxt_oe_n  = 1'b1;
					nxt_st    = perpp_pkg::CY_RECOV;
					nxt_cnt   = perpp_pkg::RECOV_LD;
				end
			end
			perpp_pkg::CY_RECOV: begin
				if (cnt_zero) begin
					nxt_done = 1'b1;
					nxt_st   = perpp_pkg::CY_IDLE;
				end
			end
			default: nxt_st = perpp_pkg::CY_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		dq_meta_ff <= data_lines_in;
		dq_sync_ff <= dq_meta_ff;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_ff    <= perpp_pkg::CY_IDLE;
			cnt_ff   <= 8'h00;
			ce_n_ff  <= 1'b1;
			oe_n_ff  <= 1'b1;
			we_n_ff  <= 1'b1;
			dq_oe_ff <= 1'b0;
			done_ff  <= 1'b0;
			fall_ff  <= 1'b0;
			addr_ff  <= '0;
			dq_ff    <= '0;
			rdata_ff <= '0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			ce_n_ff  <= nxt_ce_n;
			oe_n_ff  <= nxt_oe_n;
			we_n_ff  <= nxt_we_n;
			dq_oe_ff <= nxt_dq_oe;
			done_ff  <= nxt_done;
			fall_ff  <= nxt_fall;
			addr_ff  <= nxt_addr;
			dq_ff    <= nxt_dq;
			rdata_ff <= nxt_rdata;
		end
	end

	assign done           = done_ff;
	assign we_fall        = fall_ff;
	assign rdata          = rdata_ff;
	assign ce_n           = ce_n_ff;
	assign oe_n           = oe_n_ff;
	assign we_n           = we_n_ff;
	assign byte_address   = addr_ff;
	assign data_lines_out = dq_ff;
	assign data_lines_oe  = dq_oe_ff;

endmodule : perpp_cycle

// >>> src/perpp_host.sv
/*
 host controller for a byte-wide parallel eeprom: reads, byte and page writes,
 end-of-write polling by complemented bit 7 and the toggling bit 6.
 assumes the user port runs on core_clk and a single memory sits on the pins.
*/
`timescale 1ns/10ps
// Function
// - read only while select and output enable low
// - write needs select, strobe low, output enable high
// - page address bits fixed during page load
// - any write may grow into page load
// - next strobe fall within 100 us
// - nothing happens unless chip select low
module perpp_host #(
	parameter int WIN_CYC = perpp_pkg::PAGE_WIN_CYC
) (
	input  wire logic                        core_clk,
	input  wire logic                        srst,
	input  wire logic                        cmd_valid,
	input  wire logic                        cmd_write,
	input  wire logic [perpp_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [perpp_pkg::DATA_W-1:0] cmd_wdata,
	output logic                             cmd_ready,
	output logic                             rd_valid,
	output logic      [perpp_pkg::DATA_W-1:0] rd_data,
	output logic                             busy,
	output logic                             page_open,
	output logic                             mem_ce_n,
	output logic                             mem_oe_n,
	output logic                             mem_we_n,
	output logic      [perpp_pkg::ADDR_W-1:0] byte_address,
	output logic      [perpp_pkg::DATA_W-1:0] data_lines_out,
	output logic                             data_lines_oe,
	input  wire logic [perpp_pkg::DATA_W-1:0] data_lines_in
);

	localparam logic [15:0] WIN_LAST  = 16'(WIN_CYC - perpp_pkg::WIN_MARGIN);
	localparam logic [15:0] WIN_CLOSE = 16'(WIN_CYC + perpp_pkg::CLOSE_GUARD);
	localparam int          PG_W      = perpp_pkg::ADDR_W - perpp_pkg::PAGE_LSB;

	perpp_pkg::perpp_state_t           state_ff, nxt_state;
	logic                              pend_ff, nxt_pend, pend_write_ff;
	logic [perpp_pkg::ADDR_W-1:0]      pend_addr_ff, last_addr_ff, cy_addr;
	logic [perpp_pkg::DATA_W-1:0]      pend_data_ff, last_data_ff, rd_data_ff;
	logic [PG_W-1:0]                   page_ff;
	logic [7:0]                        bytes_ff;
	logic [15:0]                       win_ff;
	logic                              first_ff, prev_tog_ff;
	logic                              cmd_ready_ff, rd_valid_ff, busy_ff, page_open_ff;
	logic                              cy_start, cy_write, cy_done, cy_fall;
	logic [perpp_pkg::DATA_W-1:0]      cy_rdata;

	// ----------------------------------------
	// decodes
	// ----------------------------------------
	wire take       = cmd_valid & cmd_ready_ff;
	wire same_page  = (pend_addr_ff[perpp_pkg::ADDR_W-1:perpp_pkg::PAGE_LSB] == page_ff);
	wire win_ok     = (win_ff < WIN_LAST);
	wire win_done   = (win_ff >= WIN_CLOSE);
	wire page_full  = (bytes_ff == perpp_pkg::PAGE_BYTES);
	wire tog_still  = (cy_rdata[perpp_pkg::TOGGLE_BIT] == prev_tog_ff);
	wire cmpl_true  = (cy_rdata[perpp_pkg::CMPL_BIT] == last_data_ff[perpp_pkg::CMPL_BIT]);
	wire settled    = ~first_ff & tog_still & cmpl_true;
	wire wr_start   = cy_start & cy_write;
	wire poll_done  = (state_ff == perpp_pkg::ST_POLL) & cy_done;
	wire rd_done    = (state_ff == perpp_pkg::ST_RD) & cy_done;
	wire enter_poll = (state_ff == perpp_pkg::ST_WAIT) & win_done;
	wire nxt_ready  = ((nxt_state == perpp_pkg::ST_IDLE) | (nxt_state == perpp_pkg::ST_OPEN))
	                  & ~nxt_pend;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_pend  = pend_ff | take;
		cy_start  = 1'b0;
		cy_write  = 1'b0;
		cy_addr   = pend_addr_ff;
		case (state_ff)
			perpp_pkg::ST_IDLE: begin
				if (pend_ff) begin
					cy_start  = 1'b1;
					cy_write  = pend_write_ff;
					nxt_pend  = 1'b0;
					nxt_state = pend_write_ff ? perpp_pkg::ST_WR : perpp_pkg::ST_RD;
				end
			end
			perpp_pkg::ST_RD: begin
				if (cy_done) nxt_state = perpp_pkg::ST_IDLE;
			end
			perpp_pkg::ST_WR: begin
				if (cy_done) nxt_state = page_full ? perpp_pkg::ST_WAIT : perpp_pkg::ST_OPEN;
			end
			perpp_pkg::ST_OPEN: begin
				if (pend_ff & pend_write_ff & same_page & win_ok) begin
					cy_start  = 1'b1;
					cy_write  = 1'b1;
					nxt_pend  = 1'b0;
					nxt_state = perpp_pkg::ST_WR;
				end else if (pend_ff | ~win_ok) begin
					nxt_state = perpp_pkg::ST_WAIT;
				end
			end
			perpp_pkg::ST_WAIT: begin
				if (win_done) begin
					cy_start  = 1'b1;
					cy_addr   = last_addr_ff;
					nxt_state = perpp_pkg::ST_POLL;
				end
			end
			perpp_pkg::ST_POLL: begin
				if (cy_done) begin
					if (settled) begin
						nxt_state = perpp_pkg::ST_IDLE;
					end else begin
						cy_start = 1'b1;
						cy_addr  = last_addr_ff;
					end
				end
			end
			default: nxt_state = perpp_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// state and command registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_ff     <= perpp_pkg::ST_IDLE;
			pend_ff      <= 1'b0;
			cmd_ready_ff <= 1'b0;
			busy_ff      <= 1'b0;
			page_open_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			pend_ff      <= nxt_pend;
			cmd_ready_ff <= nxt_ready;
			busy_ff      <= (nxt_state == perpp_pkg::ST_WAIT) | (nxt_state == perpp_pkg::ST_POLL);
			page_open_ff <= (nxt_state == perpp_pkg::ST_WR) | (nxt_state == perpp_pkg::ST_OPEN);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pend_write_ff <= 1'b0;
			pend_addr_ff  <= '0;
			pend_data_ff  <= '0;
		end else if (take) begin
			pend_write_ff <= cmd_write;
			pend_addr_ff  <= cmd_addr;
			pend_data_ff  <= cmd_wdata;
		end
	end

	// ----------------------------------------
	// page tracking
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			last_addr_ff <= '0;
			last_data_ff <= '0;
			page_ff      <= '0;
			bytes_ff     <= 8'h00;
		end else if (wr_start) begin
			last_addr_ff <= pend_addr_ff;
			last_data_ff <= pend_data_ff;
			page_ff      <= pend_addr_ff[perpp_pkg::ADDR_W-1:perpp_pkg::PAGE_LSB];
			bytes_ff     <= (state_ff == perpp_pkg::ST_IDLE) ? 8'h01 : bytes_ff + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			win_ff <= perpp_pkg::WIN_RST;
		end else if (cy_fall) begin
			win_ff <= perpp_pkg::WIN_RST;
		end else if (win_ff != 16'hffff) begin
			win_ff <= win_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// polling and read return
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			first_ff    <= 1'b0;
			prev_tog_ff <= 1'b0;
		end else if (enter_poll) begin
			first_ff <= 1'b1;
		end else if (poll_done) begin
			first_ff    <= 1'b0;
			prev_tog_ff <= cy_rdata[perpp_pkg::TOGGLE_BIT];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_valid_ff <= 1'b0;
			rd_data_ff  <= '0;
		end else begin
			rd_valid_ff <= rd_done;
			if (rd_done) rd_data_ff <= cy_rdata;
		end
	end

	// ----------------------------------------
	// pin cycle engine
	// ----------------------------------------
	perpp_cycle u_cycle (
		.core_clk       (core_clk),
		.srst           (srst),
		.start          (cy_start),
		.is_write       (cy_write),
		.addr           (cy_addr),
		.wdata          (pend_data_ff),
		.data_lines_in  (data_lines_in),
		.done           (cy_done),
		.we_fall        (cy_fall),
		.rdata          (cy_rdata),
		.ce_n           (mem_ce_n),
		.oe_n           (mem_oe_n),
		.we_n           (mem_we_n),
		.byte_address   (byte_address),
		.data_lines_out (data_lines_out),
		.data_lines_oe  (data_lines_oe)
	);

	assign cmd_ready = cmd_ready_ff;
	assign rd_valid  = rd_valid_ff;
	assign rd_data   = rd_data_ff;
	assign busy      = busy_ff;
	assign page_open = page_open_ff;

endmodule : perpp_host

// >>> dv/perpp_host_monitor.sv
/*
 checker of the pin and user-port timing of perpp_host.
 assumes it is bound to perpp_host and sees only its ports.
*/
`timescale 1ns/10ps
module perpp_host_monitor #(
	parameter int WIN_CYC = 200
) (
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        cmd_ready,
	input wire logic        rd_valid,
	input wire logic        busy,
	input wire logic        mem_ce_n,
	input wire logic        mem_oe_n,
	input wire logic        mem_we_n,
	input wire logic [14:0] byte_address,
	input wire logic [7:0]  data_lines_out,
	input wire logic        data_lines_oe
);
	// ----------------------------------------
	// window tracking
	// ----------------------------------------
	logic [15:0] since_ff;
	logic        in_load_ff;
	logic [7:0]  pg_ff;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			since_ff   <= 16'h0000;
			in_load_ff <= 1'b0;
			pg_ff      <= 8'h00;
		end else begin
			if ($fell(mem_we_n)) begin
				since_ff   <= 16'h0000;
				in_load_ff <= 1'b1;
				pg_ff      <= byte_address[14:7];
			end else if (since_ff != 16'hffff) begin
				since_ff <= since_ff + 16'h0001;
			end
			if (busy) begin
				in_load_ff <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_no_drive_read: assert property (data_lines_oe |-> mem_oe_n)
		else $error("host drives data during read");
	a_idle_deselect: assert property (cmd_ready |-> mem_ce_n && mem_oe_n && mem_we_n)
		else $error("pins active while idle");
	a_write_levels: assert property (!mem_we_n |-> mem_oe_n && !mem_ce_n && data_lines_oe)
		else $error("write strobe without select");
	a_we_pulse_len: assert property ($fell(mem_we_n) |-> ##24 !mem_we_n ##1 mem_we_n)
		else $error("write strobe width wrong");
	a_addr_held: assert property (!mem_ce_n && $past(!mem_ce_n) |-> $stable(byte_address))
		else $error("address moved while selected");
	a_data_held: assert property (!mem_ce_n && $past(!mem_ce_n) && data_lines_oe
		|-> $stable(data_lines_out))
		else $error("write data moved while selected");
	a_read_len: assert property ($fell(mem_oe_n) |-> ##[19:21] $rose(mem_oe_n))
		else $error("read length wrong");
	a_read_answer: assert property ($rose(mem_oe_n) && !busy |-> ##[1:8] rd_valid)
		else $error("read gave no answer");
	a_page_same: assert property ($fell(mem_we_n) && in_load_ff
		|-> byte_address[14:7] == pg_ff)
		else $error("page changed in load");
	a_load_window: assert property ($fell(mem_we_n) && in_load_ff
		|-> int'(since_ff) < WIN_CYC)
		else $error("byte load too late");
	a_busy_late: assert property ($fell(mem_oe_n) && busy |-> int'(since_ff) >= WIN_CYC)
		else $error("polling before window closed");
	a_no_wr_busy: assert property (busy |-> mem_we_n)
		else $error("write while programming");
endmodule : perpp_host_monitor
bind perpp_host perpp_host_monitor #(.WIN_CYC(WIN_CYC)) u_mon (.core_clk(core_clk),
	.srst(srst), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .busy(busy),
	.mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
	.byte_address(byte_address), .data_lines_out(data_lines_out),
	.data_lines_oe(data_lines_oe));

// >>> dv/perpp_eeprom_model.sv
/*
 behavioural byte-wide eeprom with page load, self-timed programming and status bits.
 assumes pins are sampled on the core clock; timings are scaled cycle counts.
*/
`timescale 1ns/10ps
module perpp_eeprom_model #(
	parameter int WIN  = 200,
	parameter int PROG = 400
) (
	input  wire logic        core_clk,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [14:0] byte_address,
	input  wire logic [7:0]  host_q,
	input  wire logic        host_oe,
	output logic      [7:0]  dq
);
	logic [7:0]   mem [0:32767];
	logic [7:0]   pbuf [0:127];
	logic [127:0] pval;
	logic [7:0]   pg, last_q, seen;
	logic [6:0]   col;
	logic         wr_d, rd_d, tgl, loading;
	int           win_cnt, prog_cnt;
	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
		{pval, wr_d, rd_d, tgl, loading, win_cnt, prog_cnt, seen} = '0;
	end
	wire wr = !ce_n && !we_n && oe_n;
	wire rd = !ce_n && !oe_n;
	always @(posedge core_clk) begin
		wr_d <= wr;
		rd_d <= rd;
		if (rd) seen <= dq;
		if (wr && !wr_d && prog_cnt == 0) begin
			col <= byte_address[6:0];
			if (!loading) pg <= byte_address[14:7];
			loading <= 1'b1;
			win_cnt <= 0;
		end else if (loading) win_cnt <= win_cnt + 1;
		if (!wr && wr_d && loading) begin
			pbuf[col] <= host_q;
			pval[col] <= 1'b1;
			last_q <= host_q;
		end
		if (loading && win_cnt == WIN) begin
			for (int i = 0; i < 128; i++) if (pval[i]) mem[{pg, i[6:0]}] = pbuf[i];
			pval <= '0;
			loading <= 1'b0;
			prog_cnt <= PROG;
		end else if (prog_cnt > 0) prog_cnt <= prog_cnt - 1;
		if (rd && !rd_d && prog_cnt > 0) tgl <= ~tgl;
	end
	// status while busy, float pattern when released
	assign dq = rd ? (prog_cnt > 0 ? {~last_q[7], tgl, last_q[5:0]} : mem[byte_address])
		: host_oe ? host_q : ~seen;
endmodule : perpp_eeprom_model

// >>> dv/tb_top.sv
/*
 self-checking bench of perpp_host against the eeprom model.
 assumes a short page window parameter so the run stays brief.
*/
`timescale 1ns/10ps
module tb_top;
	localparam int WIN = 200;
	logic        core_clk = 1'b0, srst = 1'b1;
	logic        cmd_valid = 1'b0, cmd_write = 1'b0;
	logic [14:0] cmd_addr = 15'h0000;
	logic [7:0]  cmd_wdata = 8'h00;
	wire         cmd_ready, rd_valid, busy, page_open, ce_n, oe_n, we_n, d_oe;
	wire  [14:0] adr;
	wire  [7:0]  rd_data, d_out, d_in;
	logic [7:0]  mir [0:32767];
	logic [7:0]  expq [$];
	int          err_count = 0, n_compared = 0, cyc = 0, seed = 92;
	logic [14:0] a;
	perpp_host #(.WIN_CYC(WIN)) DUT (.core_clk(core_clk), .srst(srst),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .busy(busy), .page_open(page_open), .mem_ce_n(ce_n),
		.mem_oe_n(oe_n), .mem_we_n(we_n), .byte_address(adr),
		.data_lines_out(d_out), .data_lines_oe(d_oe), .data_lines_in(d_in));
	perpp_eeprom_model #(.WIN(WIN), .PROG(400)) u_mem (.core_clk(core_clk),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .byte_address(adr),
		.host_q(d_out), .host_oe(d_oe), .dq(d_in));
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic cmp_byte(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_compared++;
		if (got !== ex) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask : cmp_byte
	task automatic cmp_bit(input string nm, input logic ex, input logic got);
		n_compared++;
		if (got !== ex) begin
			err_count++;
			$display("mismatch %s expected %b seen %b", nm, ex, got);
		end
	endtask : cmp_bit
	task automatic stop_test;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	always @(negedge core_clk) begin
		if (rd_valid === 1'b1) begin
			if (expq.size() == 0) cmp_bit("unexpected read", 1'b0, 1'b1);
			else cmp_byte("rd_data", expq.pop_front(), rd_data);
		end
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			stop_test();
		end
	end
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	task automatic issue(input logic w, input logic [14:0] ad, input logic [7:0] d);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		cmd_addr  <= ad;
		cmd_wdata <= d;
		@(negedge core_clk);
		while (cmd_ready !== 1'b1) @(negedge core_clk);
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		if (w) mir[ad] = d;
		else expq.push_back(mir[ad]);
	endtask : issue
	task automatic settle;
		@(negedge core_clk);
		while (busy !== 1'b0 || cmd_ready !== 1'b1 || expq.size() != 0) @(negedge core_clk);
	endtask : settle
	initial begin
		for (int i = 0; i < 32768; i++) mir[i] = 8'hff;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		issue(1'b0, 15'h1234, 8'h00);
		a = 15'($random(seed));
		issue(1'b1, a, 8'h3c);
		issue(1'b0, a, 8'h00);
		issue(1'b1, a, 8'hc3);
		@(negedge core_clk);
		while (busy !== 1'b1) @(negedge core_clk);
		cmp_bit("page_open", 1'b0, page_open);
		settle();
		cmp_bit("mem_ce_n", 1'b1, ce_n);
		issue(1'b0, a, 8'h00);
		for (int i = 0; i < 128; i++) issue(1'b1, {8'h2a, 7'(i)}, 8'($random(seed)));
		for (int i = 0; i < 128; i += 31) issue(1'b0, {8'h2a, 7'(i)}, 8'h00);
		issue(1'b0, 15'h157f, 8'h00);
		for (int i = 0; i < 3; i++) issue(1'b1, {8'h05, 7'(i * 40)}, 8'(i) ^ 8'h80);
		issue(1'b1, 15'h7f01, 8'h7e);
		issue(1'b0, 15'h02d0, 8'h00);
		issue(1'b0, 15'h7f01, 8'h00);
		for (int i = 0; i < 12; i++) begin
			a = 15'($random(seed));
			issue(i[0], a, 8'($random(seed)));
			issue(1'b0, a, 8'h00);
		end
		settle();
		cmp_bit("page_open", 1'b0, page_open);
		stop_test();
	end
endmodule : tb_top
